// ===== logic/disk_controller_logic.sv
`timescale 1ns/1ns
`include "mailbox_map.svh"
// ---------------------------------------------
// Controller end: owns command and status registers.
// ---------------------------------------------
module disk_controller_logic
  import mailbox_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  mailbox_if.device bus,
  output logic [1:0] command_code,
  output logic stop_at_sector,
  output logic diagnostic,
  output logic op_start,
  input wire logic op_finish,
  input wire logic op_error,
  input wire logic fifo_empty
);

  // ---------------------------------------------
  // Registered state
  // ---------------------------------------------

  // All state sits in one record, so the reset value and the next-state
  // copy cannot drift apart when a field is added.
  typedef struct packed {
    dev_state_type state;
    logic [7:0] command;
    logic [1:0] echo;
    logic stop;
    logic diag;
    logic done;
    logic error;
    logic fifo_fault;
    logic start;
    logic irq;
  } dev_type;

  // Reset leaves the controller waiting with a cleared status byte.
  localparam dev_type dev_reset_value = '{
    state: dev_wait,
    command: `MB_COMMAND_RESET,
    echo: `MB_CODE_IDLE,
    stop: 1'b0,
    diag: 1'b0,
    done: 1'b0,
    error: 1'b0,
    fifo_fault: 1'b0,
    start: 1'b0,
    irq: 1'b0
  };

  dev_type s_reg;
  dev_type s_next;

  // ---------------------------------------------
  // Port decode
  // ---------------------------------------------

  logic port_hit;
  logic command_write;
  logic [7:0] written_command;

  assign port_hit = bus.addr == `MB_PORT_ADDR; // R1
  // Reads need no strobe: the status byte is driven at all times.
  assign command_write = bus.wr && port_hit; // R1
  // The upper byte of the port has no bits behind it.
  assign written_command = bus.wdata[7:0]; // R2

  // ---------------------------------------------
  // Command decode
  // ---------------------------------------------

  command_code_type pending_code;
  logic new_command;
  logic accept;
  logic fifo_dirty;
  logic finish_seen;
  logic finish_error;

  assign pending_code = command_code_type'(s_reg.command[1:0]); // R6
  // The echo doubles as the record of the last accepted command, so writing
  // the same code twice is a deliberate no-op; the host must change code.
  assign new_command = s_reg.command[1:0] != s_reg.echo; // R20
  assign accept = s_reg.state == dev_wait && new_command; // R20
  assign fifo_dirty = !fifo_empty; // R9
  // A FIFO fault ends the fetch at once, as the block cannot be read anyway.
  assign finish_seen = op_finish || s_reg.fifo_fault; // R13
  assign finish_error = op_error || s_reg.fifo_fault; // R17

  // ---------------------------------------------
  // Status byte
  // ---------------------------------------------

  // The byte is combinational from registered fields, so a read at any time
  // sees a settled value.
  logic [7:0] status;

  status_assembler u_status (
    .error(s_reg.error),
    .done(s_reg.done),
    .fifo_fault(s_reg.fifo_fault),
    .echoed_command_code(s_reg.echo),
    .status(status)
  );

  // ---------------------------------------------
  // Next state
  // ---------------------------------------------

  always_comb begin
    s_next = s_reg;
    s_next.start = 1'b0;
    s_next.irq = 1'b0;

    // Writes are latched in any state. A busy controller acts on a new
    // code only after the running command has finished.
    if (command_write) begin
      s_next.command = written_command; // R2
    end

    case (s_reg.state)
      dev_wait: begin
        if (accept) begin // R20
          s_next.echo = s_reg.command[1:0]; // R12
          // Flags are frozen here so that a later write cannot change the
          // mode of a command that is already running.
          s_next.stop = s_reg.command[`MB_STOP_BIT]; // R3
          s_next.diag = s_reg.command[`MB_DIAG_BIT]; // R4
          s_next.done = 1'b0; // R13
          s_next.error = 1'b0;
          s_next.fifo_fault = 1'b0;
          case (pending_code)
            cmd_idle: begin
              // Idle clears the whole byte and never interrupts.
              s_next.start = 1'b0; // R14
              s_next.irq = 1'b0; // R14
              s_next.state = dev_wait;
            end

            cmd_fetch: begin
              // A dirty FIFO would misplace the block, so it is judged at accept.
              s_next.fifo_fault = fifo_dirty; // R9
              s_next.start = 1'b1; // R6
              s_next.state = dev_busy;
            end

            cmd_execute: begin
              s_next.start = 1'b1; // R6
              s_next.state = dev_busy;
            end

            cmd_store: begin
              s_next.start = 1'b1; // R6
              s_next.state = dev_busy;
            end

            default: begin
              s_next.state = dev_wait;
            end
          endcase
        end
      end

      dev_busy: begin
        // Done, error and the interrupt are all raised on the same edge.
        if (finish_seen) begin
          s_next.done = 1'b1; // R8 R13
          s_next.error = finish_error; // R7 R17
          s_next.irq = 1'b1; // R13 R18
          s_next.state = dev_wait;
        end else begin
          s_next.state = dev_busy;
        end
      end

      default: begin
        // An unknown state falls back to waiting for a command.
        s_next.state = dev_wait;
      end
    endcase
  end

  // ---------------------------------------------
  // Registers
  // ---------------------------------------------

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= dev_reset_value;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------
  // Outputs
  // ---------------------------------------------

  assign bus.rdata = {8'h00, status}; // R2
  // Only the controller can interrupt; new work arrives through the port.
  assign bus.host_irq = s_reg.irq; // R18
  assign command_code = s_reg.echo; // R12

  // Mode flags and the start pulse go to the sector engine.
  assign stop_at_sector = s_reg.stop; // R3
  assign diagnostic = s_reg.diag; // R4
  assign op_start = s_reg.start; // R6
endmodule

// ===== logic/host_processor.sv
`timescale 1ns/1ns
`include "mailbox_map.svh"
// ---------------------------------------------
// Host end: issues one command and waits for its answer.
// ---------------------------------------------
module host_processor
  import mailbox_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  mailbox_if.host bus,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_code,
  input wire logic cmd_stop,
  input wire logic cmd_diag,
  output logic cmd_ready,
  output logic [7:0] last_status,
  output logic cmd_done
);
  typedef struct packed {
    host_state_type state;
    logic [7:0] command;
    logic [7:0] status;
    logic wr;
    logic done;
  } host_type;

  host_type s_reg;
  host_type s_next;
  logic [7:0] status_in;
  logic polling;

  assign status_in = bus.rdata[7:0];
  // The port is read only while waiting, never in the cycle of a write.
  assign polling = s_reg.state != host_ready && !s_reg.wr;

  always_comb begin
    s_next = s_reg;
    s_next.wr = 1'b0;
    s_next.done = 1'b0;
    case (s_reg.state)
      host_ready: begin
        if (cmd_valid) begin
          // Unassigned bits are always written as zero.
          s_next.command = {cmd_stop, cmd_diag, 4'h0, cmd_code}; // R5
          s_next.wr = 1'b1;
          s_next.state = host_wait_echo;
        end
      end
      host_wait_echo: begin
        if (polling && status_in[1:0] == s_reg.command[1:0]) begin
          s_next.state = (s_reg.command[1:0] == `MB_CODE_IDLE) ? host_wait_clear
                                                              : host_wait_done;
        end
      end
      host_wait_done: begin
        if (bus.host_irq && status_in[`MB_DONE_BIT]) begin // R15
          s_next.status = status_in;
          s_next.done = 1'b1;
          s_next.state = host_ready;
        end
      end
      host_wait_clear: begin
        // Idle gives no interrupt; a zero status byte ends it.
        if (status_in == `MB_STATUS_RESET) begin // R16
          s_next.status = status_in;
          s_next.done = 1'b1;
          s_next.state = host_ready;
        end
      end
      default: begin
        s_next.state = host_ready;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '{state: host_ready, command: `MB_COMMAND_RESET,
                 status: `MB_STATUS_RESET, wr: 1'b0, done: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.addr = `MB_PORT_ADDR;
  assign bus.wr = s_reg.wr;
  assign bus.rd = polling; // R1
  assign bus.wdata = {8'h00, s_reg.command};
  assign cmd_ready = s_reg.state == host_ready;
  assign last_status = s_reg.status;
  assign cmd_done = s_reg.done;
endmodule

// ===== logic/mailbox_if.sv
`timescale 1ns/1ns
interface mailbox_if;
  logic [15:0] addr;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic host_irq;

  modport device (
    input addr,
    input wr,
    input rd,
    input wdata,
    output rdata,
    output host_irq
  );
  modport host (
    output addr,
    output wr,
    output rd,
    output wdata,
    input rdata,
    input host_irq
  );
endinterface

// ===== logic/mailbox_map.svh
`ifndef MAILBOX_MAP_SVH
`define MAILBOX_MAP_SVH
// Operation
// [R1] One port: writes command, reads status.
// [R2] Only low eight port bits exist.
// [R3] Bit 7 stops at sector end.
// [R4] Bit 6 marks a diagnostic command.
// [R5] Host writes zeros in unassigned bits.
// [R6] Code: idle, fetch, execute, store block.
// [R7] Status bit 7 flags an error.
// [R8] Status bit 6 flags completion.
// [R9] Code 01 when FIFO not empty.
// [R10] Codes 10 and 11 never reported.
// [R11] Status bits 3:2 read zero.
// [R12] Status bits 1:0 echo command code.
// [R13] Accept clears done; finish sets, interrupts.
// [R14] Idle clears status, no interrupt.
// [R15] Host: fetch, execute, store, idle; waits.
// [R16] Error recovery: idle, store, idle.
// [R17] Errors go in block; ss only FIFO.
// [R18] Only controller interrupts the host.
// [R19] Host prepares FIFO before block commands.
// [R20] New command detected by code mismatch.

// ---------------------------------------------
// Port map and fields
// ---------------------------------------------
`define MB_PORT_ADDR 16'h0214
`define MB_STOP_BIT 7
`define MB_DIAG_BIT 6
`define MB_ERR_BIT 7
`define MB_DONE_BIT 6
`define MB_SS_HI 5
`define MB_SS_LO 4
`define MB_SS_FIFO 2'h1
`define MB_SS_NONE 2'h0
`define MB_STATUS_RESET 8'h00
`define MB_COMMAND_RESET 8'h00
`define MB_CODE_IDLE 2'h0
`define MB_CODE_FETCH 2'h1
`define MB_CODE_EXEC 2'h2
`define MB_CODE_STORE 2'h3
`endif

// ===== logic/mailbox_pkg.sv
package mailbox_pkg;
  typedef enum logic [1:0] {
    cmd_idle,
    cmd_fetch,
    cmd_execute,
    cmd_store
  } command_code_type;

  typedef enum {
    dev_wait,
    dev_busy
  } dev_state_type;

  typedef enum {
    host_ready,
    host_wait_echo,
    host_wait_done,
    host_wait_clear
  } host_state_type;
endpackage

// ===== logic/status_assembler.sv
`timescale 1ns/1ns
`include "mailbox_map.svh"
module status_assembler
  import mailbox_pkg::*;
(
  input wire logic error,
  input wire logic done,
  input wire logic fifo_fault,
  input wire logic [1:0] echoed_command_code,
  output logic [7:0] status
);
  always_comb begin
    status = `MB_STATUS_RESET;
    status[`MB_ERR_BIT] = error; // R7
    status[`MB_DONE_BIT] = done; // R8
    // Only the FIFO fault code is ever produced.
    status[`MB_SS_HI:`MB_SS_LO] = fifo_fault ? `MB_SS_FIFO : `MB_SS_NONE; // R9 R10
    // The host must not rely on bits 3:2, but they are still driven low.
    status[3:2] = 2'h0; // R11
    status[1:0] = echoed_command_code; // R12
  end
endmodule

// ===== verif/mailbox_assertions.sv
`timescale 1ns/1ns
// ----
// Status port checks on the shared interface.
// ----
module mailbox_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic host_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic take = wr && addr == 16'h0214;
  wire logic take_new = take && wdata[1:0] != 2'h0 && wdata[1:0] != rdata[1:0];
  a_cmd_spare_zero: assert property (wr |-> wdata[5:2] == 4'h0)
    else $error("unassigned command bits not zero");
  a_read_write_apart: assert property (!(rd && wr))
    else $error("read and write strobes overlap");
  a_high_byte: assert property (rdata[15:8] == 8'h00)
    else $error("status upper byte not zero");
  a_spare_zero: assert property (rdata[3:2] == 2'h0)
    else $error("status bits 3:2 not zero");
  a_ss_legal: assert property (rdata[5] == 1'b0)
    else $error("unassigned special code");
  a_ss_fetch: assert property (rdata[5:4] == 2'h1 |-> rdata[1:0] == 2'h1)
    else $error("fifo code outside fetch");
  a_idle_clear: assert property (take && wdata[1:0] == 2'h0 |-> ##2 rdata[7:0] == 8'h00)
    else $error("idle did not clear status");
  a_echo_accept: assert property (take_new |-> ##2 rdata[1:0] == $past(wdata[1:0], 2)
    && !rdata[6])
    else $error("accepted code not echoed");
  a_irq_done: assert property (host_irq |-> rdata[6] && rdata[1:0] != 2'h0)
    else $error("interrupt without done");
  a_irq_pulse: assert property (host_irq |=> !host_irq)
    else $error("interrupt longer than one cycle");
  a_done_irq: assert property ($rose(rdata[6]) |-> host_irq)
    else $error("done set without interrupt");
  c_irq: cover property (host_irq);
  c_fault: cover property (rdata[5:4] == 2'h1);
  c_error: cover property (rdata[7] && rdata[6]);
  c_idle: cover property (take && wdata[1:0] == 2'h0);
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ns
// ----
// Both ends joined; bench drives user sides.
// ----
module tb;
  import mailbox_pkg::*;
  logic clk = 0;
  logic resetn = 0;
  logic cmd_valid = 0, cmd_stop = 0, cmd_diag = 0;
  logic [1:0] cmd_code = 2'h0;
  logic op_finish = 0, op_error = 0, fifo_empty = 1, err_sel = 0;
  logic [1:0] command_code;
  logic stop_at_sector, diagnostic, op_start, cmd_ready, cmd_done;
  logic [7:0] last_status;
  int errors = 0, comparisons = 0, cycles = 0, seed = 32'hA0D2ABED;
  mailbox_if bus_if ();
  disk_controller_logic disk_controller_logic_i (.clk(clk), .resetn(resetn), .bus(bus_if),
    .command_code(command_code), .stop_at_sector(stop_at_sector), .diagnostic(diagnostic),
    .op_start(op_start), .op_finish(op_finish), .op_error(op_error), .fifo_empty(fifo_empty));
  host_processor host_processor_i (.clk(clk), .resetn(resetn), .bus(bus_if),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_stop(cmd_stop), .cmd_diag(cmd_diag),
    .cmd_ready(cmd_ready), .last_status(last_status), .cmd_done(cmd_done));
  mailbox_assertions mailbox_assertions_i (.clk(clk), .resetn(resetn), .addr(bus_if.addr),
    .wr(bus_if.wr), .rd(bus_if.rd), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
    .host_irq(bus_if.host_irq));
  always #2 clk = ~clk;
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  function automatic logic [7:0] expect_status(logic [1:0] c, logic e, logic f);
    if (c == 2'h0) return 8'h00;
    if (c == 2'h1 && f) return 8'hD1;
    return {e, 1'b1, 4'h0, c};
  endfunction
  // A fifo fault ends the fetch by itself, so no finish is sent for it.
  initial begin
    forever begin
      step();
      if (op_start === 1'b1 && fifo_empty === 1'b1) begin
        repeat (2 + ($random(seed) & 7)) step();
        op_finish = 1;
        op_error = err_sel;
        step();
        op_finish = 0;
        op_error = 0;
      end
    end
  end
  task automatic run(input logic [1:0] c, input logic e, input logic f);
    logic s;
    logic d;
    {s, d} = 2'($random(seed));
    cmd_code = c;
    cmd_stop = s;
    cmd_diag = d;
    err_sel = e;
    fifo_empty = !f;
    cmd_valid = 1;
    for (int i = 0; i < 50 && cmd_ready !== 1'b1; i++) step();
    chk({7'h00, cmd_ready}, 8'h01);
    step();
    cmd_valid = 0;
    for (int i = 0; i < 300 && cmd_done !== 1'b1; i++) step();
    chk({7'h00, cmd_done}, 8'h01);
    chk(last_status, expect_status(c, e, f));
    chk({6'h00, command_code}, {6'h00, c});
    chk({6'h00, stop_at_sector, diagnostic}, {6'h00, s, d});
  endtask
  // After any error the host must go idle, store the block and go idle again.
  task automatic recover();
    run(2'h0, 0, 0);
    run(2'h3, 0, 0);
    run(2'h0, 0, 0);
  endtask
  initial begin
    logic [1:0] c;
    logic e;
    logic f;
    repeat (12) @(posedge clk);
    #1 resetn = 1;
    run(2'h1, 0, 0);
    run(2'h2, 1, 0);
    recover();
    run(2'h1, 0, 1);
    recover();
    for (int i = 0; i < 6; i++) begin
      for (int k = 1; k < 5; k++) begin
        c = 2'(k);
        e = 1'($random(seed)) && c != 2'h0;
        f = c == 2'h1 && 1'($random(seed));
        run(c, e, f);
        if (e || f) begin
          recover();
          break;
        end
      end
    end
    end_of_test();
  end
endmodule
